// *** src/wdt_sleep_pkg.sv ***
// Constants for the watchdog, sleep and wake-up controller
package wdt_sleep_pkg;
    // Clock and watchdog timing
    localparam int          CLOCK_HZ         = 25000000;
    localparam int          WDT_OSC_HZ       = 1000000;
    localparam int          WDT_PERIOD_US    = 18000;
    localparam int          WDT_BASE_TICKS   = WDT_PERIOD_US * (WDT_OSC_HZ / 1000000);
    localparam int          WDT_OSC_DIV      = CLOCK_HZ / WDT_OSC_HZ;
    localparam int          OST_OSC_PERIODS  = 1024;
    localparam int          STACK_DEPTH      = 8;
    // Interrupt control bit positions
    localparam int          ICR_PORT_FLAG    = 0;
    localparam int          ICR_EDGE_FLAG    = 1;
    localparam int          ICR_TMR_FLAG     = 2;
    localparam int          ICR_PORT_EN      = 3;
    localparam int          ICR_EDGE_EN      = 4;
    localparam int          ICR_TMR_EN       = 5;
    localparam int          ICR_EE_EN        = 6;
    localparam int          ICR_GIE          = 7;
    // EEPROM control and status bit positions
    localparam int          EECR_DONE_FLAG   = 4;
    localparam int          STAT_PD          = 3;
    localparam int          STAT_TO          = 4;
    // Vectors and oscillator modes
    localparam logic [12:0] INT_VECTOR       = 13'h0004;
    localparam logic [1:0]  OSC_RC           = 2'h3;
    localparam logic [7:0]  ICR_RESET        = 8'h00;
    typedef enum logic [1:0] {
        RUN_S    = 2'b00,
        SLEEP_S  = 2'b01,
        OST_S    = 2'b10
    } pwr_state_e;
endpackage

// *** src/watchdog_sleep_wake_control.sv ***
// Watchdog timer, sleep entry and wake-up control with interrupt flag sources
// Function
// - Change on upper four port B pins sets port change flag, bit 0; enable bit 3.
// - EEPROM write completion sets done flag bit 4; enable is control bit 6.
// - Interrupt entry pushes only the return program counter.
// - Watchdog counts on its own oscillator tick, running even during sleep.
// - Watchdog timeout in normal operation causes a full device reset.
// - Watchdog timeout during sleep wakes the device without reset.
// - Watchdog enable configuration at zero disables the watchdog permanently.
// - Without prescaler the watchdog times out after nominal 18 ms.
// - Software may assign prescaler up to 1:128, giving about 2.3 seconds.
// - Clear-watchdog or sleep instruction clears counter and assigned prescaler.
// - Any watchdog timeout clears the active-low timeout flag.
// - Sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - Pins keep their drive state throughout sleep.
// - Watchdog reset never drives the external reset pin low.
// - Only reset pin, watchdog, or enabled edge/port/EEPROM interrupts wake sleep.
// - Clocked peripherals such as the timer raise no interrupts in sleep.
// - Reset pin wake resets; watchdog or interrupt wakes continue execution.
// - Sleep execution prefetches the instruction at program counter plus one.
// - Interrupt wakes only if its own enable is set, regardless of global enable.
// - After interrupt wake run next instruction, then vector to 0004h if global enable.
// - Flags set by their events regardless of individual or global enables.
// - Crystal modes wait 1024 oscillator periods after watchdog or interrupt wake; none in RC mode.
// - Timeout and power-down flags encode power-on, watchdog reset, watchdog wake.
`timescale 1ns/10ps
module watchdog_sleep_wake_control (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,

    // Reset sources
    input  wire logic        powerOnReset,
    input  wire logic        external_reset_n,

    // Configuration word
    input  wire logic        watchdog_enable_config,
    input  wire logic [1:0]  oscMode,

    // Prescaler assignment from the option register
    input  wire logic        prescalerToWdt,
    input  wire logic [2:0]  prescalerRate,

    // Core instruction strobes
    input  wire logic        clear_watchdog_instr,
    input  wire logic        sleepInstr,
    input  wire logic        retfieInstr,
    input  wire logic        instrStep,
    input  wire logic [12:0] programCounter,

    // Interrupt control register writes
    input  wire logic        icrWrite,
    input  wire logic [7:0]  icrWriteData,
    input  wire logic        eecrDoneClear,

    // Event sources
    input  wire logic [3:0]  port_b_a,
    input  wire logic        edgeEvent,
    input  wire logic        timerOverflow,
    input  wire logic        eepromWriteDone,

    // Pin drive from the port logic
    input  wire logic [12:0] pinOutIn,
    input  wire logic [12:0] pinOeIn,

    // Status and control outputs
    output logic [7:0]  interrupt_control_reg,
    output logic        eeprom_write_done_flag,
    output logic        timeout_flag_n,
    output logic        power_down_flag_n,
    output logic        deviceReset,
    output logic        externalResetOe,
    output logic        oscDriverOn,
    output logic        coreRun,
    output logic        vectorTake,
    output logic [12:0] vectorAddr,
    output logic [12:0] prefetchAddr,
    output logic [12:0] stackTop,
    output logic [12:0] pinOut,
    output logic [12:0] pinOe
);
    // Power state

    wdt_sleep_pkg::pwr_state_e stateReg;

    // Watchdog time base, counter and prescaler

    logic [4:0]  wdtDivReg;
    logic [14:0] wdtCountReg;
    logic [6:0]  prescaleReg;

    // Port history, start-up count and return stack

    logic [3:0]  portPrevReg;
    logic [10:0] ostCountReg;
    logic [2:0]  stackPtrReg;
    logic [12:0] stackMem [wdt_sleep_pkg::STACK_DEPTH];
    logic        pendingVectorReg;

    // Decoded events

    logic        wdtTick;
    logic        wdtStep;
    logic        wdtTimeout;
    logic        wdtClear;
    logic        asleep;
    logic        wakeIrq;
    logic        irqReq;
    logic [7:0]  icr;

    // A tick every WDT_OSC_DIV clocks stands in for the watchdog oscillator.
    // With the prescaler on, each timeout count waits 2^rate ticks.
    // Rate zero counts every tick, as if no prescaler were assigned.

    assign asleep   = (stateReg == wdt_sleep_pkg::SLEEP_S);
    assign icr      = interrupt_control_reg;
    assign wdtClear = clear_watchdog_instr || sleepInstr;
    assign wdtTick  = (wdtDivReg == 5'(wdt_sleep_pkg::WDT_OSC_DIV - 1));
    // Prescaler picks every 2^rate-th tick
    assign wdtStep  = wdtTick && (!prescalerToWdt ||
                      prescaleReg == ((7'h01 << prescalerRate) - 7'h01)
                      || (prescalerRate == 3'h0));
    assign wdtTimeout = watchdog_enable_config && wdtStep &&
                        (wdtCountReg == 15'(wdt_sleep_pkg::WDT_BASE_TICKS - 1));

    // Enabled port, edge and EEPROM flags wake the core whatever the global enable
    assign wakeIrq  = (icr[wdt_sleep_pkg::ICR_PORT_EN] && icr[wdt_sleep_pkg::ICR_PORT_FLAG])
                   || (icr[wdt_sleep_pkg::ICR_EDGE_EN] && icr[wdt_sleep_pkg::ICR_EDGE_FLAG])
                   || (icr[wdt_sleep_pkg::ICR_EE_EN] && eeprom_write_done_flag);
    // Vector request in run mode needs the global enable
    assign irqReq   = icr[wdt_sleep_pkg::ICR_GIE] && (wakeIrq ||
                      (icr[wdt_sleep_pkg::ICR_TMR_EN] && icr[wdt_sleep_pkg::ICR_TMR_FLAG]));

    // Watchdog oscillator tick, free running even in sleep
    // Nothing but reset stops this divider, so sleep never halts it
    always_ff @(posedge clock) begin
        if (!rst_n || powerOnReset || wdtTick) begin
            wdtDivReg <= 5'h00;
        end else begin
            wdtDivReg <= wdtDivReg + 5'h01;
        end
    end

    // Prescaler and watchdog counter
    // Clear instruction, sleep or a zero enable bit hold both at zero
    // A timeout restarts the count so a wake starts a fresh period
    // Counter steps only on a prescaler carry
    always_ff @(posedge clock) begin
        if (!rst_n || powerOnReset || wdtClear || !watchdog_enable_config) begin
            prescaleReg <= 7'h00;
            wdtCountReg <= 15'h0000;
        end else if (wdtTick) begin
            prescaleReg <= wdtStep ? 7'h00 : prescaleReg + 7'h01;
            if (wdtTimeout) begin
                wdtCountReg <= 15'h0000;
            end else if (wdtStep) begin
                wdtCountReg <= wdtCountReg + 15'h0001;
            end
        end
    end

    // Device reset: watchdog in run mode or reset pin; pin itself never driven
    // A timeout while asleep is a wake, not a reset
    // The pin output enable stays low so the pin is never pulled
    // Power-on and reset pin hold it for as long as they last
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            deviceReset     <= 1'b1;
            externalResetOe <= 1'b0;
        end else begin
            deviceReset     <= powerOnReset || !external_reset_n ||
                               (wdtTimeout && !asleep);
            externalResetOe <= 1'b0;
        end
    end

    // Sleep state machine with oscillator start-up delay
    // Wake goes to OST in crystal modes
    // and straight back to RUN in RC mode
    // Reset pin or power-on forces RUN at once
    always_ff @(posedge clock) begin
        if (!rst_n || powerOnReset || !external_reset_n) begin
            stateReg    <= wdt_sleep_pkg::RUN_S;
            ostCountReg <= 11'h000;
            oscDriverOn <= 1'b1;
        end else begin
            case (stateReg)
                wdt_sleep_pkg::RUN_S: begin
                    if (sleepInstr) begin
                        stateReg    <= wdt_sleep_pkg::SLEEP_S;
                        oscDriverOn <= 1'b0;
                    end
                end
                // Wait for a timeout or an enabled flag
                wdt_sleep_pkg::SLEEP_S: begin
                    if (wdtTimeout || wakeIrq) begin
                        oscDriverOn <= 1'b1;
                        ostCountReg <= 11'h000;
                        stateReg    <= (oscMode == wdt_sleep_pkg::OSC_RC) ?
                                       wdt_sleep_pkg::RUN_S : wdt_sleep_pkg::OST_S;
                    end
                end
                // Count start-up periods before running
                wdt_sleep_pkg::OST_S: begin
                    if (ostCountReg == 11'(wdt_sleep_pkg::OST_OSC_PERIODS - 1)) begin
                        stateReg <= wdt_sleep_pkg::RUN_S;
                    end else begin
                        ostCountReg <= ostCountReg + 11'h001;
                    end
                end
                // Unused code returns to RUN
                default: begin
                    stateReg <= wdt_sleep_pkg::RUN_S;
                end
            endcase
        end
    end

    // Core runs only in RUN and not in the cycle of the sleep strobe,
    // so the instruction after sleep waits for the wake
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            coreRun <= 1'b0;
        end else begin
            coreRun <= (stateReg == wdt_sleep_pkg::RUN_S) && !sleepInstr;
        end
    end

    // Status flags: timeout and power-down
    // Timeout wins over clear and sleep in the same cycle
    // Power-on sets both; a watchdog reset leaves power-down as it was,
    // and a watchdog wake leaves both low
    always_ff @(posedge clock) begin
        if (!rst_n || powerOnReset) begin
            timeout_flag_n    <= 1'b1;
            power_down_flag_n <= 1'b1;
        end else if (wdtTimeout) begin
            timeout_flag_n    <= 1'b0;
        end else if (clear_watchdog_instr) begin
            timeout_flag_n    <= 1'b1;
            power_down_flag_n <= 1'b1;
        end else if (sleepInstr) begin
            timeout_flag_n    <= 1'b1;
            power_down_flag_n <= 1'b0;
        end
    end

    // Interrupt control register; events win over software clear
    // Flags set whatever the enables, so software can poll them
    // Timer flag is blocked in sleep since its clock is stopped there
    // Global enable drops on vectoring and returns on interrupt return
    always_ff @(posedge clock) begin
        if (!rst_n || deviceReset) begin
            interrupt_control_reg <= wdt_sleep_pkg::ICR_RESET;
            portPrevReg           <= port_b_a;
        end else begin
            logic [7:0] nextIcr;
            nextIcr = icrWrite ? icrWriteData : interrupt_control_reg;
            if (port_b_a != portPrevReg) begin
                nextIcr[wdt_sleep_pkg::ICR_PORT_FLAG] = 1'b1;
            end
            if (edgeEvent) begin
                nextIcr[wdt_sleep_pkg::ICR_EDGE_FLAG] = 1'b1;
            end
            if (timerOverflow && !asleep) begin
                nextIcr[wdt_sleep_pkg::ICR_TMR_FLAG] = 1'b1;
            end
            // Vectoring takes precedence over a return in the same cycle
            if (vectorTake) begin
                nextIcr[wdt_sleep_pkg::ICR_GIE] = 1'b0;
            end else if (retfieInstr) begin
                nextIcr[wdt_sleep_pkg::ICR_GIE] = 1'b1;
            end
            interrupt_control_reg <= nextIcr;
            portPrevReg           <= port_b_a;
        end
    end

    // EEPROM write done flag; a completion beats a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n || deviceReset) begin
            eeprom_write_done_flag <= 1'b0;
        end else if (eepromWriteDone) begin
            eeprom_write_done_flag <= 1'b1;
        end else if (eecrDoneClear) begin
            eeprom_write_done_flag <= 1'b0;
        end
    end

    // Prefetch of the instruction after sleep and interrupt vectoring
    // A wake by an enabled flag records the global enable; the next
    // instruction step then vectors if it was set, else runs in line
    // One step always passes first so the prefetched word runs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prefetchAddr     <= 13'h0000;
            pendingVectorReg <= 1'b0;
            vectorTake       <= 1'b0;
            vectorAddr       <= 13'h0000;
        end else begin
            // Address of the word after the current one
            prefetchAddr <= programCounter + 13'h0001;
            vectorTake   <= 1'b0;
            if (asleep && wakeIrq) begin
                pendingVectorReg <= icr[wdt_sleep_pkg::ICR_GIE];
            end else if (coreRun && instrStep && (pendingVectorReg || irqReq)
                         && !vectorTake) begin
                pendingVectorReg <= 1'b0;
                vectorTake       <= icr[wdt_sleep_pkg::ICR_GIE];
                vectorAddr       <= wdt_sleep_pkg::INT_VECTOR;
            end
        end
    end

    // Return address stack; nothing else is saved
    // Working and status registers are left to software
    // Eight entries; an overflow wraps and overwrites the oldest
    // Pop reads two below the pointer since the top copy is registered
    always_ff @(posedge clock) begin
        if (!rst_n || deviceReset) begin
            stackPtrReg <= 3'h0;
            stackTop    <= 13'h0000;
        end else if (vectorTake) begin
            stackMem[stackPtrReg] <= prefetchAddr;
            stackTop              <= prefetchAddr;
            stackPtrReg           <= stackPtrReg + 3'h1;
        end else if (retfieInstr) begin
            stackPtrReg <= stackPtrReg - 3'h1;
            stackTop    <= stackMem[stackPtrReg - 3'h2];
        end
    end

    // Pin drive frozen during sleep
    // Last drive before sleep is kept: level and enable both hold
    // Port logic may keep changing its request; only the latch is gated
    // Outputs follow the request one cycle late in run mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pinOut <= 13'h0000;
            pinOe  <= 13'h0000;
        end else if (stateReg == wdt_sleep_pkg::RUN_S && !sleepInstr) begin
            pinOut <= pinOutIn;
            pinOe  <= pinOeIn;
        end
    end
endmodule

// *** tb/wdt_pin_partner.sv ***
// Model of the reset pin and upper port pins facing the controller
`timescale 1ns/10ps
module wdt_pin_partner (
    // Clock
    input  wire logic       clock,
    // Requests from the bench
    input  wire logic [3:0] portReq,
    input  wire logic       resetReq,
    // Pins toward the controller
    output logic      [3:0] port_b_a,
    output logic            external_reset_n
);
    // Levels only move on the falling edge and then hold whole cycles
    always @(negedge clock) begin
        port_b_a <= portReq;
        external_reset_n <= !resetReq;
    end
endmodule

// *** tb/wdt_sleep_monitor.sv ***
// Port assertions for the watchdog, sleep and wake-up controller
`timescale 1ns/10ps
module wdt_sleep_monitor (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Inputs
    input wire logic        powerOnReset,
    input wire logic        external_reset_n,
    input wire logic        watchdog_enable_config,
    input wire logic        sleepInstr,
    input wire logic        icrWrite,
    input wire logic        eepromWriteDone,
    input wire logic        timerOverflow,
    input wire logic [3:0]  port_b_a,
    input wire logic [12:0] programCounter,
    // Outputs
    input wire logic [7:0]  interrupt_control_reg,
    input wire logic        eeprom_write_done_flag,
    input wire logic        timeout_flag_n,
    input wire logic        power_down_flag_n,
    input wire logic        deviceReset,
    input wire logic        externalResetOe,
    input wire logic        oscDriverOn,
    input wire logic        coreRun,
    input wire logic        vectorTake,
    input wire logic [12:0] vectorAddr,
    input wire logic [12:0] prefetchAddr,
    input wire logic [12:0] pinOut,
    input wire logic [12:0] pinOe
);
    logic [7:0] icr;
    logic       wakeAny;
    logic       quiet;
    assign icr = interrupt_control_reg;
    assign wakeAny = (icr[0] & icr[3]) | (icr[1] & icr[4]) | (eeprom_write_done_flag & icr[6]);
    assign quiet = external_reset_n && !powerOnReset && !deviceReset;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    pin_no_drive_a: assert property (externalResetOe == 1'b0) else $error("reset pin driven");
    port_flag_a: assert property (quiet && $changed(port_b_a) |=> icr[0])
        else $error("port change flag not set");
    ee_flag_a: assert property (quiet && eepromWriteDone |=> eeprom_write_done_flag)
        else $error("eeprom done flag not set");
    sleep_entry_a: assert property (quiet && coreRun && sleepInstr |=>
        !power_down_flag_n && timeout_flag_n && !oscDriverOn && !coreRun) else $error("sleep entry");
    prefetch_next_a: assert property (sleepInstr |=> prefetchAddr == $past(programCounter) + 13'h0001)
        else $error("prefetch address wrong");
    pins_frozen_a: assert property (!oscDriverOn && !$past(oscDriverOn) |->
        $stable(pinOut) && $stable(pinOe)) else $error("pins moved in sleep");
    timer_sleep_a: assert property (timerOverflow && !oscDriverOn && !icr[2] && !icrWrite |=> !icr[2])
        else $error("timer flag set in sleep");
    stay_asleep_a: assert property (!oscDriverOn && !wakeAny && quiet && !watchdog_enable_config
        |=> !oscDriverOn) else $error("spurious wake");
    wake_on_irq_a: assert property (!oscDriverOn && wakeAny && quiet |=> oscDriverOn)
        else $error("no wake on enabled flag");
    vector_gie_a: assert property (vectorTake |-> vectorAddr == 13'h0004 && $past(icr[7]))
        else $error("vector without global enable");
    wdt_off_a: assert property (!watchdog_enable_config && timeout_flag_n |=> timeout_flag_n)
        else $error("timeout with watchdog off");
    pin_reset_a: assert property (!external_reset_n |=> deviceReset)
        else $error("reset pin ignored");
endmodule
bind watchdog_sleep_wake_control wdt_sleep_monitor mon (.clock(clock), .rst_n(rst_n),
    .powerOnReset(powerOnReset), .external_reset_n(external_reset_n), .sleepInstr(sleepInstr),
    .watchdog_enable_config(watchdog_enable_config), .icrWrite(icrWrite), .port_b_a(port_b_a),
    .eepromWriteDone(eepromWriteDone), .timerOverflow(timerOverflow), .coreRun(coreRun),
    .programCounter(programCounter), .interrupt_control_reg(interrupt_control_reg),
    .eeprom_write_done_flag(eeprom_write_done_flag), .timeout_flag_n(timeout_flag_n),
    .power_down_flag_n(power_down_flag_n), .deviceReset(deviceReset), .pinOe(pinOe),
    .externalResetOe(externalResetOe), .oscDriverOn(oscDriverOn), .vectorTake(vectorTake),
    .vectorAddr(vectorAddr), .prefetchAddr(prefetchAddr), .pinOut(pinOut));

// *** tb/test_watchdog_sleep_wake_control.sv ***
// Self-checking bench for the watchdog, sleep and wake-up controller
`timescale 1ns/10ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED at %0t: %s", $time, m); end end
module test_watchdog_sleep_wake_control;
    logic clock, rst_n, powerOnReset, watchdog_enable_config, prescalerToWdt, clear_watchdog_instr;
    logic sleepInstr, retfieInstr, instrStep, icrWrite, eecrDoneClear, edgeEvent, timerOverflow;
    logic eepromWriteDone, resetReq, external_reset_n, eeprom_write_done_flag, timeout_flag_n;
    logic power_down_flag_n, deviceReset, externalResetOe, oscDriverOn, coreRun, vectorTake, vtSeen;
    logic [1:0]  oscMode;
    logic [2:0]  prescalerRate;
    logic [3:0]  portReq, port_b_a;
    logic [7:0]  icrWriteData, interrupt_control_reg;
    logic [12:0] programCounter, pinOutIn, pinOeIn, vectorAddr, prefetchAddr, stackTop, pinOut, pinOe;
    logic [12:0] pinHold, oeHold;
    logic [31:0] rnd, waitOk, expQ[$];
    int          selQ[$], err_count, cmp_count, cycles, n;
    string       msgQ[$];
    watchdog_sleep_wake_control dut (.clock(clock), .rst_n(rst_n), .powerOnReset(powerOnReset),
        .external_reset_n(external_reset_n), .watchdog_enable_config(watchdog_enable_config),
        .oscMode(oscMode), .prescalerToWdt(prescalerToWdt), .prescalerRate(prescalerRate),
        .clear_watchdog_instr(clear_watchdog_instr), .sleepInstr(sleepInstr), .stackTop(stackTop),
        .retfieInstr(retfieInstr), .instrStep(instrStep), .programCounter(programCounter),
        .icrWrite(icrWrite), .icrWriteData(icrWriteData), .eecrDoneClear(eecrDoneClear),
        .port_b_a(port_b_a), .edgeEvent(edgeEvent), .timerOverflow(timerOverflow),
        .eepromWriteDone(eepromWriteDone), .pinOutIn(pinOutIn), .pinOeIn(pinOeIn),
        .interrupt_control_reg(interrupt_control_reg), .eeprom_write_done_flag(eeprom_write_done_flag),
        .timeout_flag_n(timeout_flag_n), .power_down_flag_n(power_down_flag_n), .coreRun(coreRun),
        .deviceReset(deviceReset), .externalResetOe(externalResetOe), .oscDriverOn(oscDriverOn),
        .vectorTake(vectorTake), .vectorAddr(vectorAddr), .prefetchAddr(prefetchAddr),
        .pinOut(pinOut), .pinOe(pinOe));
    wdt_pin_partner partner (.clock(clock), .portReq(portReq), .resetReq(resetReq),
        .port_b_a(port_b_a), .external_reset_n(external_reset_n));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [31:0] observe(int s);
        case (s)
            0: return 32'(interrupt_control_reg);
            1: return 32'(eeprom_write_done_flag);
            2: return 32'(timeout_flag_n);
            3: return 32'(power_down_flag_n);
            4: return 32'(oscDriverOn);
            5: return 32'(coreRun);
            6: return 32'(deviceReset);
            7: return 32'(prefetchAddr);
            8: return 32'({pinOut, pinOe});
            9: return 32'(vtSeen);
            11: return 32'(stackTop);
            default: return waitOk;
        endcase
    endfunction
    task automatic tick(int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic note(int s, logic [31:0] v, string m);
        selQ.push_back(s);
        expQ.push_back(v);
        msgQ.push_back(m);
        tick(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic write_icr(logic [7:0] d);
        icrWriteData = d;
        pulse(icrWrite);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Every queued note is compared once the outputs of this edge have settled
    always @(posedge clock) begin
        #1;
        while (expQ.size() > 0) begin
            `CHK(observe(selQ.pop_front()), expQ.pop_front(), msgQ.pop_front())
        end
    end
    always @(posedge clock) begin
        if (vectorTake === 1'b1) vtSeen <= 1'b1;
        else if (!rst_n) vtSeen <= 1'b0;
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, retfieInstr, sleepInstr, clear_watchdog_instr, instrStep, icrWrite} = '0;
        {eecrDoneClear, edgeEvent, timerOverflow, eepromWriteDone, resetReq} = '0;
        {portReq, icrWriteData, programCounter, pinOutIn, pinOeIn} = '0;
        {powerOnReset, watchdog_enable_config, oscMode} = 4'hF;
        rnd = 32'h0000005B;
        rnd = xs(rnd);
        {prescalerToWdt, prescalerRate} = rnd[3:0];
        repeat (6) @(posedge clock);
        tick(1);
        rst_n = 1'b1;
        powerOnReset = 1'b0;
        tick(2);
        note(2, 1, "timeout flag after power-on");
        note(3, 1, "power-down flag after power-on");
        $display("test power-on done");
        rnd = xs(rnd);
        portReq = rnd[3:0] | 4'h1;
        tick(2);
        pulse(eepromWriteDone);
        pulse(edgeEvent);
        tick(1);
        note(0, 32'h03, "flags set with enables off");
        note(1, 1, "eeprom done flag");
        write_icr(8'h08);
        pulse(eecrDoneClear);
        $display("test flags done");
        watchdog_enable_config = 1'b0;
        {programCounter, pinOutIn, pinOeIn} = {rnd[31:19], rnd[12:0], rnd[25:13]};
        tick(1);
        {pinHold, oeHold} = {pinOutIn, pinOeIn};
        pulse(sleepInstr);
        note(3, 0, "power-down flag cleared in sleep");
        note(2, 1, "timeout flag set in sleep");
        note(4, 0, "oscillator driver off");
        note(7, 32'(programCounter + 13'h0001), "prefetch address");
        {pinOutIn, pinOeIn} = ~{pinOutIn, pinOeIn};
        pulse(timerOverflow);
        pulse(edgeEvent);
        tick(3);
        note(8, 32'({pinHold, oeHold}), "pins held in sleep");
        note(0, 32'h0A, "timer flag blocked, edge flag set");
        note(4, 0, "disabled flag keeps sleep");
        portReq = ~portReq;
        tick(5);
        note(5, 1, "port change wakes in RC mode");
        pulse(instrStep);
        tick(2);
        note(9, 0, "no vector with global enable off");
        pulse(clear_watchdog_instr);
        tick(1);
        note(3, 1, "clear restores power-down flag");
        $display("test sleep wake done");
        oscMode = 2'h1;
        write_icr(8'hC0);
        pulse(sleepInstr);
        tick(2);
        pulse(eepromWriteDone);
        n = 0;
        while (coreRun !== 1'b1 && n < 1200) begin
            tick(1);
            n++;
        end
        waitOk = 32'(n >= 1024 && n <= 1030);
        note(10, 1, "start-up delay length");
        pulse(instrStep);
        tick(2);
        note(9, 1, "vector after wake with global enable");
        note(11, 32'(programCounter + 13'h0001), "return address pushed");
        $display("test crystal wake done");
        oscMode = 2'h3;
        write_icr(8'h00);
        pulse(sleepInstr);
        tick(2);
        resetReq = 1'b1;
        tick(3);
        note(6, 1, "reset pin wake resets device");
        resetReq = 1'b0;
        tick(3);
        note(6, 0, "reset released");
        $display("test reset pin wake done");
        report_and_stop();
    end
endmodule
